// ==== rtcat_alarm_trim.sv ====
`include "rtcat_params.svh"
module rtcat_alarm_trim
  import rtcat_pkg::*;
#(
  parameter int TICKS_PER_MINUTE = 120,
  parameter int HALF_SEC_TICKS = 1
)
(
  // clock and power-on reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // avalon-mm slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // time base: one pulse per half second, plus calendar rollover strobes
  input wire logic half_sec_tick_in,
  input wire logic [9:0] period_hit_in,
  // pulse adjust: request to add or drop one rtc pulse
  output logic pulse_add_out,
  output logic pulse_drop_out,
  output logic alarm_event_out,
  output logic irq_out
);
  import rtcat_pkg::*;

  rtcat_bus_req_s req;
  logic [15:0] cal_ff, nxt_cal;
  logic [15:0] alm_ff, nxt_alm;
  logic [1:0] stat_ff, nxt_stat;
  logic [1:0] mask_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [15:0] minute_ff;
  logic [9:0] trim_left_ff;
  rtcat_trim_e trim_st_ff, nxt_trim_st;
  logic [15:0] minutes_seconds_value_ff;

  assign req = '{addr: avs_address_in, read: avs_read_in, write: avs_write_in,
                 wdata: avs_writedata_in};

  // one wait state: answer in the cycle after the request appears
  wire access = (req.read | req.write) & ~ack_ff;
  assign avs_waitrequest_out = (req.read | req.write) & ~ack_ff;
  wire wr = req.write & ack_ff;
  wire wr_cal = wr & (req.addr == `RTCAT_OFF_CAL);
  wire wr_alm = wr & (req.addr == `RTCAT_OFF_ALM);
  wire wr_minutes_seconds_value = wr & (req.addr == `RTCAT_OFF_MINUTES_SECONDS_VALUE);
  wire wr_stat = wr & (req.addr == `RTCAT_OFF_STAT);
  wire wr_mask = wr & (req.addr == `RTCAT_OFF_MASK);

  // trim magnitude: code*4 forward, (-code)*4 backward
  wire signed [7:0] trim_code = cal_ff[7:0];
  wire trim_neg = trim_code[7];
  wire [8:0] trim_mag = trim_neg ? (9'h100 - {1'b0, cal_ff[7:0]}) : {1'b0, cal_ff[7:0]};
  wire [9:0] trim_pulses = {trim_mag[7:0], 2'b00} | (trim_mag[8] ? 10'h200 : 10'h000);
  wire minute_tick = half_sec_tick_in & (minute_ff == 16'(TICKS_PER_MINUTE - 1));

  // interval decode: code selects which period strobe fires
  wire [3:0] int_sel = alm_ff[`RTCAT_ALM_INT_HI:`RTCAT_ALM_INT_LO];
  wire int_valid = (int_sel <= 4'h9);
  wire interval_hit = int_valid & period_hit_in[int_sel];
  wire alarm_fire = alm_ff[`RTCAT_ALM_ARM] & half_sec_tick_in & interval_hit;
  wire [7:0] rpt = alm_ff[7:0];
  wire roll = alm_ff[`RTCAT_ALM_ROLL];

  // register next values
  always_comb
  begin
    nxt_cal = cal_ff;
    if (wr_cal)
    begin
      nxt_cal[7:0] = req.wdata[7:0];
      nxt_cal[`RTCAT_CAL_UNLOCK] = req.wdata[`RTCAT_CAL_UNLOCK];
      if (cal_ff[`RTCAT_CAL_UNLOCK])
        nxt_cal[`RTCAT_CAL_RUN] = req.wdata[`RTCAT_CAL_RUN];
    end
    if (half_sec_tick_in)
      nxt_cal[`RTCAT_CAL_SYNC] = 1'b1;
    if (wr_minutes_seconds_value)
      nxt_cal[`RTCAT_CAL_SYNC] = 1'b0;
  end

  always_comb
  begin
    nxt_alm = alm_ff;
    if (wr_alm)
      nxt_alm = req.wdata[15:0];
    else if (alarm_fire)
    begin
      if (rpt != 8'h00)
        nxt_alm[7:0] = rpt - 8'h01;
      else if (roll)
        nxt_alm[7:0] = 8'hff;
      if (rpt == 8'h00 && !roll)
        nxt_alm[`RTCAT_ALM_ARM] = 1'b0;
    end
  end

  // status sticky: hardware set beats software clear
  always_comb
  begin
    nxt_stat = stat_ff;
    if (wr_stat)
      nxt_stat = stat_ff & ~req.wdata[1:0];
    if (alarm_fire)
      nxt_stat[`RTCAT_ST_ALARM] = 1'b1;
    if (minute_tick && trim_pulses != 10'h000)
      nxt_stat[`RTCAT_ST_TRIM] = 1'b1;
  end

  always_comb
  begin
    nxt_trim_st = trim_st_ff;
    if (minute_tick && cal_ff[`RTCAT_CAL_RUN])
    begin
      if (trim_pulses == 10'h000)
        nxt_trim_st = RTCAT_IDLE;
      else
        nxt_trim_st = trim_neg ? RTCAT_DROP : RTCAT_ADD;
    end
    else
    begin
      case (trim_st_ff)
        RTCAT_ADD, RTCAT_DROP:
          if (trim_left_ff == 10'h001)
            nxt_trim_st = RTCAT_IDLE;
        default:
          nxt_trim_st = RTCAT_IDLE;
      endcase
    end
  end

  // the only reset here is power-on, so cal is cleared by it alone
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      cal_ff <= `RTCAT_CAL_RESET;
      alm_ff <= `RTCAT_ALM_RESET;
      stat_ff <= 2'b00;
      mask_ff <= 2'b00;
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      minute_ff <= 16'h0000;
      trim_st_ff <= RTCAT_IDLE;
      trim_left_ff <= 10'h000;
      minutes_seconds_value_ff <= 16'h0000;
    end
    else
    begin
      cal_ff <= nxt_cal;
      alm_ff <= nxt_alm;
      stat_ff <= nxt_stat;
      ack_ff <= access;
      trim_st_ff <= nxt_trim_st;
      if (wr_mask)
        mask_ff <= req.wdata[1:0];
      if (wr_minutes_seconds_value)
        minutes_seconds_value_ff <= req.wdata[15:0];
      if (half_sec_tick_in)
        minute_ff <= minute_tick ? 16'h0000 : minute_ff + 16'h0001;
      if (minute_tick && cal_ff[`RTCAT_CAL_RUN])
        trim_left_ff <= trim_pulses;
      else if (trim_st_ff != RTCAT_IDLE)
        trim_left_ff <= trim_left_ff - 10'h001;
      if (access && req.read)
      begin
        case (req.addr)
          `RTCAT_OFF_CAL: rdata_ff <= {16'h0000, cal_ff};
          `RTCAT_OFF_ALM: rdata_ff <= {16'h0000, alm_ff};
          `RTCAT_OFF_MINUTES_SECONDS_VALUE: rdata_ff <= {16'h0000, minutes_seconds_value_ff};
          `RTCAT_OFF_STAT: rdata_ff <= {30'h0, stat_ff};
          `RTCAT_OFF_MASK: rdata_ff <= {30'h0, mask_ff};
          default: rdata_ff <= `RTCAT_BAD_DATA;
        endcase
      end
    end
  end

  assign avs_readdata_out = rdata_ff;
  assign pulse_add_out = (trim_st_ff == RTCAT_ADD);
  assign pulse_drop_out = (trim_st_ff == RTCAT_DROP);
  assign alarm_event_out = alarm_fire;
  assign irq_out = |(stat_ff & mask_ff);

  // one pulse per cycle for trim_pulses cycles after a minute boundary
  int unsigned burst_cnt;
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in || (minute_tick && cal_ff[`RTCAT_CAL_RUN]))
      burst_cnt <= 0;
    else if (pulse_add_out || pulse_drop_out)
      burst_cnt <= burst_cnt + 1;
  end

  sequence s_fire_last;
    alarm_fire && rpt == 8'h00 && !roll;
  endsequence

  AST_MAX_POS: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    minute_tick && cal_ff[`RTCAT_CAL_RUN] && cal_ff[7:0] == 8'h7f |=> trim_left_ff == 10'd508)
    else $error("max positive trim not 508");
  AST_ONE_POS: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    minute_tick && cal_ff[`RTCAT_CAL_RUN] && cal_ff[7:0] == 8'h01
    |=> pulse_add_out [*4] ##1 !pulse_add_out)
    else $error("trim one not four pulses");
  AST_ZERO: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    minute_tick && cal_ff[7:0] == 8'h00 |=> !pulse_add_out && !pulse_drop_out)
    else $error("zero trim moved pulses");
  AST_MINUS_ONE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    minute_tick && cal_ff[`RTCAT_CAL_RUN] && cal_ff[7:0] == 8'hff
    |=> pulse_drop_out [*4] ##1 !pulse_drop_out)
    else $error("minus one not four drops");
  AST_MAX_NEG: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    minute_tick && cal_ff[`RTCAT_CAL_RUN] && cal_ff[7:0] == 8'h80 |=> trim_left_ff == 10'd512)
    else $error("max negative trim not 512");
  AST_BURST: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    burst_cnt <= 512)
    else $error("trim burst too long");
  AST_RUN_LOCK: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_cal && !cal_ff[`RTCAT_CAL_UNLOCK] |=> $stable(cal_ff[`RTCAT_CAL_RUN]))
    else $error("run bit written while locked");
  AST_SYNC_CLR: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_minutes_seconds_value && !half_sec_tick_in |=> !cal_ff[`RTCAT_CAL_SYNC])
    else $error("status bit not cleared");
  AST_RPT_DEC: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    alarm_fire && !wr_alm && rpt != 8'h00 |=> alm_ff[7:0] == $past(rpt) - 8'h01)
    else $error("repeat count not decremented");
  AST_DISARM: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_fire_last and !wr_alm |=> !alm_ff[`RTCAT_ALM_ARM] && alm_ff[7:0] == 8'h00)
    else $error("alarm not disarmed");
  AST_WRAP: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    alarm_fire && !wr_alm && rpt == 8'h00 && roll |=> alm_ff[7:0] == 8'hff)
    else $error("repeat count did not wrap");
  AST_RESET: assert property (@(posedge clk_in)
    sys_rst_in |=> alm_ff == 16'h0000 && cal_ff == 16'h0000)
    else $error("reset values wrong");

  // trim load and burst steps, shared by the burst checks
  sequence s_load_add;
    minute_tick && cal_ff[`RTCAT_CAL_RUN] && !trim_neg && trim_pulses != 10'h000;
  endsequence
  sequence s_load_drop;
    minute_tick && cal_ff[`RTCAT_CAL_RUN] && trim_neg && trim_pulses != 10'h000;
  endsequence
  sequence s_burst_step;
    trim_st_ff != RTCAT_IDLE && !(minute_tick && cal_ff[`RTCAT_CAL_RUN]);
  endsequence

  // bus handshake: exactly one wait state
  AST_WAIT_FIRST: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("waitrequest held too long");
  AST_ACK_DROP: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ack_ff |=> !ack_ff)
    else $error("acknowledge longer than one cycle");
  AST_WAIT_IDLE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
    else $error("waitrequest without request");

  // register storage and read path
  AST_TRIM_WRITE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_cal |=> cal_ff[7:0] == $past(req.wdata[7:0]))
    else $error("trim code not stored");
  AST_RUN_UNLOCKED: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_cal && cal_ff[`RTCAT_CAL_UNLOCK] |=> cal_ff[`RTCAT_CAL_RUN] == $past(req.wdata[15]))
    else $error("run bit not written while unlocked");
  AST_ALM_WRITE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_alm |=> alm_ff == $past(req.wdata[15:0]))
    else $error("alarm config not stored");
  AST_MINUTES_SECONDS_VALUE_STORE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_minutes_seconds_value |=> minutes_seconds_value_ff == $past(req.wdata[15:0]))
    else $error("minutes-seconds not stored");
  AST_MASK_STORE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_mask |=> mask_ff == $past(req.wdata[1:0]))
    else $error("mask not stored");
  AST_READ_CAL: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    access && req.read && req.addr == `RTCAT_OFF_CAL |=> avs_readdata_out == {16'h0000, $past(cal_ff)})
    else $error("calibration read wrong");
  AST_READ_ALM: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    access && req.read && req.addr == `RTCAT_OFF_ALM |=> avs_readdata_out == {16'h0000, $past(alm_ff)})
    else $error("alarm config read wrong");
  AST_READ_STAT: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    access && req.read && req.addr == `RTCAT_OFF_STAT |=> avs_readdata_out == {30'h0, $past(stat_ff)})
    else $error("status read wrong");
  AST_BAD_READ: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    access && req.read && req.addr > `RTCAT_OFF_MASK |=> avs_readdata_out == `RTCAT_BAD_DATA)
    else $error("unmapped read wrong");

  // sync bit: clear on minutes-seconds write beats the tick
  AST_SYNC_SET: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    half_sec_tick_in && !wr_minutes_seconds_value |=> cal_ff[`RTCAT_CAL_SYNC])
    else $error("sync bit not set");

  // alarm decode and repeat handling
  AST_FIRE_DEF: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    alarm_event_out |-> alm_ff[`RTCAT_ALM_ARM] && half_sec_tick_in && int_sel <= 4'h9)
    else $error("alarm fired without cause");
  AST_RESERVED: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    int_sel > 4'h9 |-> !alarm_event_out)
    else $error("reserved interval fired");
  AST_EVENT_DISARMED: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !alm_ff[`RTCAT_ALM_ARM] |-> !alarm_event_out)
    else $error("disarmed alarm fired");
  AST_ARM_HOLD: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    alarm_fire && !wr_alm && (rpt != 8'h00 || roll) |=> alm_ff[`RTCAT_ALM_ARM])
    else $error("alarm disarmed too early");
  AST_ALM_QUIET: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !alarm_fire && !wr_alm |=> $stable(alm_ff))
    else $error("alarm config changed unprompted");

  // sticky status, set wins over clear
  AST_ST_ALARM: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    alarm_fire |=> stat_ff[`RTCAT_ST_ALARM])
    else $error("alarm status not set");
  AST_ST_TRIM: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    minute_tick && trim_pulses != 10'h000 |=> stat_ff[`RTCAT_ST_TRIM])
    else $error("trim status not set");
  AST_W1C: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_stat && !alarm_fire && !minute_tick |=> (stat_ff & $past(req.wdata[1:0])) == 2'b00)
    else $error("status not cleared");
  AST_IRQ_MASKED: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    mask_ff == 2'b00 |-> !irq_out)
    else $error("masked interrupt raised");

  // trim burst shape
  AST_ONE_DIR: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !(pulse_add_out && pulse_drop_out))
    else $error("add and drop together");
  AST_ADD_DIR: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_load_add |=> pulse_add_out)
    else $error("positive trim did not add");
  AST_DROP_DIR: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_load_drop |=> pulse_drop_out)
    else $error("negative trim did not drop");
  AST_NO_RUN: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    minute_tick && !cal_ff[`RTCAT_CAL_RUN] && trim_st_ff == RTCAT_IDLE |=> trim_st_ff == RTCAT_IDLE)
    else $error("trim ran while stopped");
  AST_LEFT_DEC: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_burst_step |=> trim_left_ff == $past(trim_left_ff) - 10'h001)
    else $error("burst count not decremented");
  AST_BURST_END: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_burst_step ##0 trim_left_ff == 10'h001 |=> trim_st_ff == RTCAT_IDLE)
    else $error("burst did not end");
  AST_MINUTE_WRAP: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    minute_tick |=> minute_ff == 16'h0000)
    else $error("minute counter did not wrap");
endmodule

// ==== rtcat_alarm_trim_test.sv ====
`include "rtcat_params.svh"
module rtcat_alarm_trim_test;
  timeunit 1ns;
  timeprecision 1ns;
  import rtcat_pkg::*;
  logic clk_in = 0, sys_rst_in = 1, avs_read_in = 0, avs_write_in = 0, half_sec_tick_in = 0;
  logic [3:0] avs_address_in = 0;
  logic [31:0] avs_writedata_in = 0, avs_readdata_out, q, seed = 32'h2bd3;
  logic [9:0] period_hit_in = 0;
  logic avs_waitrequest_out, pulse_add_out, pulse_drop_out, alarm_event_out, irq_out;
  logic [15:0] d;
  logic [7:0] codes [6];
  int err_total = 0, check_count = 0, n_add = 0, n_drop = 0, n_ev = 0;
  always #10 clk_in = ~clk_in;
  // counted mid-cycle so the main process never races the counters
  always @(negedge clk_in)
  begin
    n_add += pulse_add_out;
    n_drop += pulse_drop_out;
    n_ev += alarm_event_out;
  end
  rtcat_alarm_trim #(.TICKS_PER_MINUTE(4), .HALF_SEC_TICKS(1)) u_rtcat_alarm_trim (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .half_sec_tick_in(half_sec_tick_in), .period_hit_in(period_hit_in),
    .pulse_add_out(pulse_add_out), .pulse_drop_out(pulse_drop_out),
    .alarm_event_out(alarm_event_out), .irq_out(irq_out));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] pulses(input logic [7:0] c, input logic add);
    if (add)
      return c[7] ? 32'h0 : 32'(c) * 4;
    return c[7] ? (32'd256 - 32'(c)) * 4 : 32'h0;
  endfunction
  task summarize;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [15:0] wd, output logic [31:0] rd);
    int n;
    avs_address_in <= a;
    avs_writedata_in <= {16'h0000, wd};
    avs_read_in <= !wr;
    avs_write_in <= wr;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (avs_waitrequest_out !== 1'b0 && n < 50);
    if (n >= 50)
    begin
      err_total++;
      summarize;
    end
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task tick(input logic [9:0] hit, input int gap);
    half_sec_tick_in <= 1'b1;
    period_hit_in <= hit;
    @(posedge clk_in);
    half_sec_tick_in <= 1'b0;
    period_hit_in <= 10'(rnd());
    repeat (gap) @(posedge clk_in);
  endtask
  initial
  begin
    codes = '{8'h7f, 8'h01, 8'h00, 8'hff, 8'h00, 8'h80};
    codes[4] = 8'(rnd());
    repeat (20) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    bus(0, `RTCAT_OFF_CAL, 0, q);
    check(q, 0);
    bus(0, `RTCAT_OFF_ALM, 0, q);
    check(q, 0);
    bus(1, `RTCAT_OFF_CAL, 16'h2000, q);
    // whole minutes only, so the boundary phase stays aligned
    foreach (codes[i])
    begin
      bus(1, `RTCAT_OFF_CAL, {8'ha0, codes[i]}, q);
      n_add = 0;
      n_drop = 0;
      repeat (4) tick(10'(rnd()), 600);
      check(n_add, pulses(codes[i], 1));
      check(n_drop, pulses(codes[i], 0));
    end
    bus(0, `RTCAT_OFF_STAT, 0, q);
    check(q & 32'h3, 32'h2);
    $display("trim test done");
    bus(1, `RTCAT_OFF_CAL, 16'h0001, q);
    bus(1, `RTCAT_OFF_CAL, 16'h8001, q);
    bus(0, `RTCAT_OFF_CAL, 0, q);
    check(q & 32'hefff, 32'h1);
    n_add = 0;
    repeat (4) tick(10'(rnd()), 20);
    check(n_add, 0);
    check(q[12], 1);
    bus(1, `RTCAT_OFF_MINUTES_SECONDS_VALUE, 16'(rnd()), q);
    bus(0, `RTCAT_OFF_CAL, 0, q);
    check(q[12], 0);
    $display("lock test done");
    for (int c = 0; c < 10; c++)
    begin
      d = {2'b11, 4'(c), 2'(rnd()), 8'h00};
      bus(1, `RTCAT_OFF_ALM, d, q);
      n_ev = 0;
      tick(10'h1 << c, 3);
      tick(~(10'h1 << c), 3);
      check(n_ev, 1);
      bus(0, `RTCAT_OFF_ALM, 0, q);
      check(q, {16'h0, d[15:8], 8'hff});
    end
    bus(1, `RTCAT_OFF_ALM, 16'h9002, q);
    n_ev = 0;
    repeat (2) tick(10'h010, 3);
    bus(0, `RTCAT_OFF_ALM, 0, q);
    check(q, 32'h9000);
    tick(10'h010, 3);
    bus(0, `RTCAT_OFF_ALM, 0, q);
    check(q, 32'h1000);
    tick(10'h010, 3);
    check(n_ev, 3);
    bus(0, `RTCAT_OFF_STAT, 0, q);
    check(q[0], 1);
    check(irq_out, 0);
    bus(1, `RTCAT_OFF_MASK, 16'h0001, q);
    check(irq_out, 1);
    bus(1, `RTCAT_OFF_STAT, 16'h0001, q);
    check(irq_out, 0);
    $display("alarm test done");
    bus(0, 4'h7, 0, q);
    check(q, `RTCAT_BAD_DATA);
    bus(1, 4'h7, 16'hffff, q);
    bus(0, `RTCAT_OFF_CAL, 0, q);
    check(q & 32'hefff, 32'h1);
    sys_rst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    bus(0, `RTCAT_OFF_CAL, 0, q);
    check(q, 0);
    bus(0, `RTCAT_OFF_ALM, 0, q);
    check(q, 0);
    $display("reset test done");
    summarize;
  end
endmodule

// ==== rtcat_params.svh ====
// Function
// - largest positive trim code inserts 508 extra pulses each minute
// - trim code one inserts 4 pulses; each step adds four more
// - trim code zero adds or removes no pulses
// - trim code all ones removes 4 pulses each minute
// - most negative trim code removes 512 pulses each minute
// - calibration register reset only by power-on reset
// - run bit write accepted only while write unlock is set
// - read-only status bit cleared on write of low minutes-seconds half
// - alarm config: arm 15, rollover 14, interval 13:10, pointer 9:8, reset zero
// - interval select fires alarm at decoded period, half second to yearly
// - repeat counter counts remaining alarms, decrements per alarm event
`ifndef RTCAT_PARAMS_SVH
`define RTCAT_PARAMS_SVH
`define RTCAT_OFF_CAL 4'h0
`define RTCAT_OFF_ALM 4'h1
`define RTCAT_OFF_MINUTES_SECONDS_VALUE 4'h2
`define RTCAT_OFF_STAT 4'h3
`define RTCAT_OFF_MASK 4'h4
`define RTCAT_CAL_RUN 15
`define RTCAT_CAL_UNLOCK 13
`define RTCAT_CAL_SYNC 12
`define RTCAT_ALM_ARM 15
`define RTCAT_ALM_ROLL 14
`define RTCAT_ALM_INT_HI 13
`define RTCAT_ALM_INT_LO 10
`define RTCAT_ALM_PTR_HI 9
`define RTCAT_ALM_PTR_LO 8
`define RTCAT_PULSE_STEP 10'h004
`define RTCAT_ALM_RESET 16'h0000
`define RTCAT_CAL_RESET 16'h0000
`define RTCAT_ST_ALARM 0
`define RTCAT_ST_TRIM 1
`define RTCAT_BAD_DATA 32'hdead_0000
`endif

// ==== rtcat_pkg.sv ====
package rtcat_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic read;
    logic write;
    logic [31:0] wdata;
  } rtcat_bus_req_s;
  typedef enum logic [1:0] {
    RTCAT_IDLE = 2'b00,
    RTCAT_ADD = 2'b01,
    RTCAT_DROP = 2'b10
  } rtcat_trim_e;
endpackage
